//--- rtl/radio_framer_defines.vh
// Summary of operation
// - Preamble byte alternates, 10101010 if first address bit is 1, else 01010101.
// - Address is three, four or five bytes, shared by transmit and receive.
// - Send preamble, address, 9-bit control, payload, CRC; each field MSB first.
// - Control field is 6-bit length, 2-bit packet identity, 1-bit skip-ack.
// - Length code is the byte count; 0 for empty acks, above 32 don't-care.
// - Dynamic length puts loaded byte count in length field; static ignores it.
// - Packet identity increments per new packet, unchanged on retransmission.
// - Same identity and same CRC as previous packet means duplicate, discarded.
// - Auto-acknowledge is not sent for a packet whose skip-ack flag is high.
// - Skip-ack write with selective ack enabled sets flag, no ack wait.
// - Payload is 0 to 32 bytes, sent exactly as uploaded.
// - CRC is one or two bytes over address, control and payload, not preamble.
// - One-byte CRC uses x^8+x^2+x+1, preset to all ones.
// - Two-byte CRC uses x^16+x^12+x^5+1, preset to all ones.
// - One configuration bit selects CRC length for generation and checking.
// - Packets failing CRC are rejected and never reach the receive buffer; the code still writes their bytes to rx_mem when not full, no data-ready.
// - Receiver scans bit stream for address, captures, checks CRC, stores payload.
// - Static length default; receiver uses static width, transmitter must match.
// - Dynamic length takes received length field, readable through width register.
// - Transmitter takes address from transmit-address register, payload from buffer.
// - Transmitter listens for ack after data; receiver acks valid packet.
// - Validated packet payload goes to receive buffer and raises data-ready flag; the code skips both while the buffer is still full or the length is 0.
`ifndef RADIO_FRAMER_DEFINES_VH
`define RADIO_FRAMER_DEFINES_VH
// ==========================================
// Register offsets
`define REG_CONFIG 8'h00
`define REG_STATIC_WIDTH 8'h04
`define REG_TX_ADDR_LO 8'h08
`define REG_TX_ADDR_HI 8'h0c
`define REG_RX_ADDR_LO 8'h10
`define REG_RX_ADDR_HI 8'h14
`define REG_TX_DATA 8'h18
`define REG_TX_DATA_SKIPACK 8'h1c
`define REG_COMMAND 8'h20
`define REG_STATUS 8'h24
`define REG_RX_WIDTH 8'h28
`define REG_RX_DATA 8'h2c
// ==========================================
// Field positions
`define CFG_CRC2 2
`define CFG_PRIM_RX 3
`define CFG_AUTO_ACK 4
`define CFG_DYN_EN 5
`define CFG_PIPE0_DYN 6
`define CFG_SEL_ACK 7
`define CMD_START 0
`define CMD_FLUSH 1
`define ST_RX_READY 0
`define ST_TX_DONE 1
`define ST_MAX_RETRY 2
// ==========================================
// Reset values and codes
`define CONFIG_RESET 8'h13
`define STATIC_WIDTH_RESET 6'h00
`define ADDR_RESET 40'he7e7e7e7e7
`define PRE_ONE 8'haa
`define PRE_ZERO 8'h55
`define CRC8_POLY 8'h07
`define CRC8_INIT 8'hff
`define CRC16_POLY 16'h1021
`define CRC16_INIT 16'hffff
`define MAX_PAYLOAD 6'h20
// ==========================================
// Timing
`define CLK_MHZ 250
`define ACK_WAIT_US 250
`define ACK_WAIT_CYC (`ACK_WAIT_US * `CLK_MHZ)
`define RETRY_MAX 3
`endif

//--- rtl/radio_packet_link_framer.v
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "radio_framer_defines.vh"
module radio_packet_link_framer #(
  parameter ACK_WAIT_CYCLES = `ACK_WAIT_CYC,
  parameter RETRY_MAX = `RETRY_MAX
) (
  // Clock and reset
  input wire clk_in,
  input wire rst_in,
  // APB slave
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  output wire [31:0] prdata_out,
  output wire pready_out,
  output wire pslverr_out,
  // Transmit bit stream to modulator
  input wire tx_ready_in,
  output wire tx_bit_out,
  output wire tx_strobe_out,
  // Receive bit stream from demodulator
  input wire rx_valid_in,
  input wire rx_bit_in,
  output wire rx_listen_out
);
  localparam ST_IDLE = 3'b001;
  localparam ST_SEND = 3'b010;
  localparam ST_WAIT = 3'b100;
  localparam F_PRE = 5'b00001;
  localparam F_ADR = 5'b00010;
  localparam F_CTL = 5'b00100;
  localparam F_PAY = 5'b01000;
  localparam F_CRC = 5'b10000;
  localparam R_HUNT = 4'b0001;
  localparam R_CTL = 4'b0010;
  localparam R_PAY = 4'b0100;
  localparam R_CRC = 4'b1000;

  // ==========================================
  // CRC helpers
  function [15:0] crc_step;
    input [15:0] c;
    input b;
    input wide;
    reg fb;
    begin
      if (wide) begin
        fb = b ^ c[15];
        crc_step = {c[14:0], 1'b0} ^ (fb ? `CRC16_POLY : 16'h0000);
      end else begin
        fb = b ^ c[7];
        crc_step = {8'h00, c[6:0], 1'b0} ^ {8'h00, (fb ? `CRC8_POLY : 8'h00)};
      end
    end
  endfunction

  function [15:0] crc_init;
    input wide;
    begin
      crc_init = wide ? `CRC16_INIT : {8'h00, `CRC8_INIT};
    end
  endfunction

  // Address bits preloaded in one go since the receiver only learns of them at match
  function [15:0] crc_addr;
    input [39:0] a;
    input [5:0] n;
    input wide;
    integer i;
    reg [15:0] c;
    begin
      c = crc_init(wide);
      for (i = 39; i >= 0; i = i - 1) begin
        if (i < n)
          c = crc_step(c, a[i], wide);
      end
      crc_addr = c;
    end
  endfunction

  // ==========================================
  // State
  reg [7:0] cfg_q;
  reg [5:0] swidth_q;
  reg [39:0] txa_q;
  reg [39:0] rxa_q;
  reg [7:0] tx_mem [0:31];
  reg [7:0] rx_mem [0:31];
  reg [5:0] tx_cnt_q;
  reg tx_skip_q;
  reg [1:0] pid_q;
  reg [2:0] st_q;
  reg [4:0] fld_q;
  reg [8:0] bit_q;
  reg [15:0] crc_q;
  reg is_ack_q;
  reg [1:0] ack_pid_q;
  reg ack_req_q;
  reg [7:0] retry_q;
  reg [31:0] wait_q;
  reg tx_bit_q;
  reg tx_stb_q;
  reg [39:0] rsh_q;
  reg [3:0] rph_q;
  reg [8:0] rcnt_q;
  reg [8:0] rctl_q;
  reg [5:0] rlen_q;
  reg [15:0] rcrc_q;
  reg [15:0] rgot_q;
  reg [7:0] rbyte_q;
  reg have_prev_q;
  reg [1:0] prev_pid_q;
  reg [15:0] prev_crc_q;
  reg rx_full_q;
  reg [5:0] rx_width_q;
  reg [5:0] rd_ptr_q;
  reg rx_data_ready_irq_q;
  reg tx_ds_q;
  reg max_q;
  reg [31:0] prdata_q;
  reg pready_q;
  reg pslverr_q;

  // ==========================================
  // Configuration decode
  wire crc2 = cfg_q[`CFG_CRC2];
  wire prim_rx = cfg_q[`CFG_PRIM_RX];
  wire dyn = cfg_q[`CFG_DYN_EN] & cfg_q[`CFG_PIPE0_DYN];
  wire [2:0] aw_bytes = (cfg_q[1:0] == 2'b10) ? 3'd4 : ((cfg_q[1:0] == 2'b11) ? 3'd5 : 3'd3);
  wire [5:0] abits = {aw_bytes, 3'b000};
  wire [8:0] crc_bits = crc2 ? 9'd16 : 9'd8;

  // ==========================================
  // Transmit serializer
  wire [5:0] tx_len = is_ack_q ? 6'd0 : tx_cnt_q;
  wire skip_flag = ~is_ack_q & tx_skip_q & cfg_q[`CFG_SEL_ACK];
  wire [8:0] ctrl9 = {(dyn ? tx_len : 6'd0), (is_ack_q ? ack_pid_q : pid_q), skip_flag};
  wire [5:0] aidx = abits - 6'd1 - bit_q[5:0];
  wire [5:0] apre = abits - 6'd1;
  wire [7:0] preamble = txa_q[apre] ? `PRE_ONE : `PRE_ZERO;
  wire [7:0] pay_byte = tx_mem[bit_q[7:3]];
  wire [3:0] cidx = crc_bits[3:0] - 4'd1 - bit_q[3:0];
  reg cur_bit;
  reg [8:0] fld_len;
  always @* begin
    cur_bit = 1'b0;
    fld_len = 9'd8;
    case (fld_q)
      F_PRE: begin
        cur_bit = preamble[3'd7 - bit_q[2:0]];
      end
      F_ADR: begin
        cur_bit = txa_q[aidx];
        fld_len = {3'b000, abits};
      end
      F_CTL: begin
        cur_bit = ctrl9[4'd8 - bit_q[3:0]];
        fld_len = 9'd9;
      end
      F_PAY: begin
        cur_bit = pay_byte[3'd7 - bit_q[2:0]];
        fld_len = {tx_len, 3'b000};
      end
      F_CRC: begin
        cur_bit = crc_q[cidx];
        fld_len = crc_bits;
      end
      default: begin
        cur_bit = 1'b0;
      end
    endcase
  end
  wire fld_last = (bit_q == fld_len - 9'd1);

  // ==========================================
  // Receive deframer
  wire listen = (st_q == ST_IDLE && prim_rx) || st_q == ST_WAIT;
  wire [39:0] rsh_n = {rsh_q[38:0], rx_bit_in};
  wire [39:0] amask = ~(40'hffffffffff << abits);
  wire addr_hit = ((rsh_n ^ rxa_q) & amask) == 40'h0000000000;
  wire [8:0] rctl_n = {rctl_q[7:0], rx_bit_in};
  wire [5:0] rlen_sel = dyn ? rctl_n[8:3] : swidth_q;
  wire [15:0] rgot_n = {rgot_q[14:0], rx_bit_in};
  wire [15:0] rcrc_n = crc_step(rcrc_q, rx_bit_in, crc2);
  wire rx_end = rph_q == R_CRC && rx_valid_in && rcnt_q == crc_bits - 9'd1;
  wire good = rx_end && rgot_n == rcrc_q;
  wire dup = have_prev_q && rctl_q[2:1] == prev_pid_q && rcrc_q == prev_crc_q;
  wire full_drop = rx_full_q && rlen_q != 6'd0;
  wire deliver = good && !dup && !rx_full_q && rlen_q != 6'd0;

  // ==========================================
  // APB decode
  wire access = psel_in & penable_in & ~pready_q;
  wire fire = psel_in & penable_in & pready_q;
  wire wr = fire & pwrite_in;
  wire rd = fire & ~pwrite_in;
  wire is_txd = paddr_in == `REG_TX_DATA || paddr_in == `REG_TX_DATA_SKIPACK;
  reg [31:0] rmux;
  reg mapped;
  always @* begin
    rmux = 32'h00000000;
    mapped = 1'b1;
    case (paddr_in)
      `REG_CONFIG: rmux = {24'h000000, cfg_q};
      `REG_STATIC_WIDTH: rmux = {26'h0000000, swidth_q};
      `REG_TX_ADDR_LO: rmux = txa_q[31:0];
      `REG_TX_ADDR_HI: rmux = {24'h000000, txa_q[39:32]};
      `REG_RX_ADDR_LO: rmux = rxa_q[31:0];
      `REG_RX_ADDR_HI: rmux = {24'h000000, rxa_q[39:32]};
      `REG_TX_DATA: rmux = 32'h00000000;
      `REG_TX_DATA_SKIPACK: rmux = 32'h00000000;
      `REG_COMMAND: rmux = 32'h00000000;
      `REG_STATUS: rmux = {19'h00000, tx_cnt_q, rx_full_q, pid_q, (st_q != ST_IDLE), max_q, tx_ds_q, rx_data_ready_irq_q};
      `REG_RX_WIDTH: rmux = {26'h0000000, rx_width_q};
      `REG_RX_DATA: rmux = {24'h000000, rx_mem[rd_ptr_q[4:0]]};
      default: mapped = 1'b0;
    endcase
  end
  wire stat_wr = wr && paddr_in == `REG_STATUS;
  wire start_cmd = wr && paddr_in == `REG_COMMAND && pwdata_in[`CMD_START];
  wire flush_cmd = wr && paddr_in == `REG_COMMAND && pwdata_in[`CMD_FLUSH];
  reg tx_done_set;
  reg max_set;
  always @* begin
    tx_done_set = 1'b0;
    max_set = 1'b0;
    if (st_q == ST_SEND && tx_ready_in && fld_q == F_CRC && fld_last && !is_ack_q && skip_flag)
      tx_done_set = 1'b1;
    if (st_q == ST_WAIT && good)
      tx_done_set = 1'b1;
    if (st_q == ST_WAIT && !good && wait_q == ACK_WAIT_CYCLES - 1 && retry_q >= RETRY_MAX)
      max_set = 1'b1;
  end

  // ==========================================
  // Sequential logic
  always @(posedge clk_in) begin
    if (rst_in) begin
      cfg_q <= `CONFIG_RESET;
      swidth_q <= `STATIC_WIDTH_RESET;
      txa_q <= `ADDR_RESET;
      rxa_q <= `ADDR_RESET;
      tx_cnt_q <= 6'd0;
      tx_skip_q <= 1'b0;
      pid_q <= 2'd0;
      st_q <= ST_IDLE;
      fld_q <= F_PRE;
      bit_q <= 9'd0;
      crc_q <= 16'h0000;
      is_ack_q <= 1'b0;
      ack_pid_q <= 2'd0;
      ack_req_q <= 1'b0;
      retry_q <= 8'h00;
      wait_q <= 32'h00000000;
      tx_bit_q <= 1'b0;
      tx_stb_q <= 1'b0;
      rsh_q <= 40'h0000000000;
      rph_q <= R_HUNT;
      rcnt_q <= 9'd0;
      rctl_q <= 9'd0;
      rlen_q <= 6'd0;
      rcrc_q <= 16'h0000;
      rgot_q <= 16'h0000;
      rbyte_q <= 8'h00;
      have_prev_q <= 1'b0;
      prev_pid_q <= 2'd0;
      prev_crc_q <= 16'h0000;
      rx_full_q <= 1'b0;
      rx_width_q <= 6'd0;
      rd_ptr_q <= 6'd0;
      rx_data_ready_irq_q <= 1'b0;
      tx_ds_q <= 1'b0;
      max_q <= 1'b0;
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      // One wait state so read data leaves from a flop
      pready_q <= access;
      // Error flag pulses with pready only, never lingers into later cycles
      pslverr_q <= access & ~mapped;
      if (access) begin
        prdata_q <= rmux;
      end
      if (wr) begin
        case (paddr_in)
          `REG_CONFIG: cfg_q <= pwdata_in[7:0];
          `REG_STATIC_WIDTH: swidth_q <= pwdata_in[5:0];
          `REG_TX_ADDR_LO: txa_q[31:0] <= pwdata_in;
          `REG_TX_ADDR_HI: txa_q[39:32] <= pwdata_in[7:0];
          `REG_RX_ADDR_LO: rxa_q[31:0] <= pwdata_in;
          `REG_RX_ADDR_HI: rxa_q[39:32] <= pwdata_in[7:0];
          default: begin
          end
        endcase
      end
      // Payload loads refused while a packet is in flight or buffer is full
      if (wr && is_txd && st_q == ST_IDLE && tx_cnt_q < `MAX_PAYLOAD) begin
        tx_mem[tx_cnt_q[4:0]] <= pwdata_in[7:0];
        tx_cnt_q <= tx_cnt_q + 6'd1;
        tx_skip_q <= ((tx_cnt_q == 6'd0) ? 1'b0 : tx_skip_q) | (paddr_in == `REG_TX_DATA_SKIPACK);
      end
      if (flush_cmd && st_q == ST_IDLE)
        tx_cnt_q <= 6'd0;
      // Sticky flags: hardware set wins over software clear
      rx_data_ready_irq_q <= deliver | (rx_data_ready_irq_q & ~(stat_wr & pwdata_in[`ST_RX_READY]));
      tx_ds_q <= tx_done_set | (tx_ds_q & ~(stat_wr & pwdata_in[`ST_TX_DONE]));
      max_q <= max_set | (max_q & ~(stat_wr & pwdata_in[`ST_MAX_RETRY]));
      if (rd && paddr_in == `REG_RX_DATA && rx_full_q) begin
        rd_ptr_q <= rd_ptr_q + 6'd1;
        if (rd_ptr_q == rx_width_q - 6'd1)
          rx_full_q <= 1'b0;
      end

      // Transmit engine
      tx_stb_q <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (ack_req_q) begin
            ack_req_q <= 1'b0;
            is_ack_q <= 1'b1;
            st_q <= ST_SEND;
            fld_q <= F_PRE;
            bit_q <= 9'd0;
            crc_q <= crc_init(crc2);
          end else if (start_cmd && !prim_rx && tx_cnt_q != 6'd0) begin
            is_ack_q <= 1'b0;
            pid_q <= pid_q + 2'd1;
            retry_q <= 8'h00;
            st_q <= ST_SEND;
            fld_q <= F_PRE;
            bit_q <= 9'd0;
            crc_q <= crc_init(crc2);
          end
        end
        ST_SEND: begin
          if (tx_ready_in) begin
            tx_bit_q <= cur_bit;
            tx_stb_q <= 1'b1;
            if (fld_q == F_ADR || fld_q == F_CTL || fld_q == F_PAY)
              crc_q <= crc_step(crc_q, cur_bit, crc2);
            if (!fld_last) begin
              bit_q <= bit_q + 9'd1;
            end else begin
              bit_q <= 9'd0;
              case (fld_q)
                F_PRE: fld_q <= F_ADR;
                F_ADR: fld_q <= F_CTL;
                F_CTL: fld_q <= (tx_len == 6'd0) ? F_CRC : F_PAY;
                F_PAY: fld_q <= F_CRC;
                default: begin
                  if (is_ack_q) begin
                    st_q <= ST_IDLE;
                  end else if (skip_flag) begin
                    st_q <= ST_IDLE;
                    tx_cnt_q <= 6'd0;
                  end else begin
                    st_q <= ST_WAIT;
                    wait_q <= 32'h00000000;
                  end
                end
              endcase
            end
          end
        end
        ST_WAIT: begin
          wait_q <= wait_q + 32'h00000001;
          if (good) begin
            st_q <= ST_IDLE;
            tx_cnt_q <= 6'd0;
          end else if (wait_q == ACK_WAIT_CYCLES - 1) begin
            if (retry_q < RETRY_MAX) begin
              // Retransmission keeps the identity
              retry_q <= retry_q + 8'h01;
              st_q <= ST_SEND;
              fld_q <= F_PRE;
              bit_q <= 9'd0;
              crc_q <= crc_init(crc2);
            end else begin
              st_q <= ST_IDLE;
              tx_cnt_q <= 6'd0;
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase

      // Receive engine; capture aborts if listening stops
      if (rx_valid_in)
        rsh_q <= rsh_n;
      if (!listen) begin
        rph_q <= R_HUNT;
      end else if (rx_valid_in) begin
        rcnt_q <= rcnt_q + 9'd1;
        case (rph_q)
          R_HUNT: begin
            if (addr_hit) begin
              rph_q <= R_CTL;
              rcnt_q <= 9'd0;
              rcrc_q <= crc_addr(rxa_q, abits, crc2);
            end
          end
          R_CTL: begin
            rctl_q <= rctl_n;
            rcrc_q <= rcrc_n;
            if (rcnt_q == 9'd8) begin
              rcnt_q <= 9'd0;
              rlen_q <= rlen_sel;
              rgot_q <= 16'h0000;
              if (rlen_sel > `MAX_PAYLOAD)
                rph_q <= R_HUNT;
              else
                rph_q <= (rlen_sel == 6'd0) ? R_CRC : R_PAY;
            end
          end
          R_PAY: begin
            rcrc_q <= rcrc_n;
            rbyte_q <= {rbyte_q[6:0], rx_bit_in};
            if (rcnt_q[2:0] == 3'd7 && !rx_full_q)
              rx_mem[rcnt_q[7:3]] <= {rbyte_q[6:0], rx_bit_in};
            if (rcnt_q == {rlen_q, 3'b000} - 9'd1) begin
              rcnt_q <= 9'd0;
              rph_q <= R_CRC;
            end
          end
          R_CRC: begin
            rgot_q <= rgot_n;
            if (rx_end)
              rph_q <= R_HUNT;
          end
          default: rph_q <= R_HUNT;
        endcase
      end
      if (good) begin
        have_prev_q <= 1'b1;
        prev_pid_q <= rctl_q[2:1];
        prev_crc_q <= rcrc_q;
        if (st_q == ST_IDLE && cfg_q[`CFG_AUTO_ACK] && !rctl_q[0] && !(full_drop && !dup)) begin
          ack_req_q <= 1'b1;
          ack_pid_q <= rctl_q[2:1];
        end
      end
      if (deliver) begin
        rx_full_q <= 1'b1;
        rx_width_q <= rlen_q;
        rd_ptr_q <= 6'd0;
      end
    end
  end

  // ==========================================
  // Outputs
  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign tx_bit_out = tx_bit_q;
  assign tx_strobe_out = tx_stb_q;
  assign rx_listen_out = listen;
endmodule

//--- bench/radio_framer_monitor.sv
`timescale 1ns/1ps
module radio_framer_monitor #(
  parameter ACK_WAIT_CYCLES = 200,
  parameter RETRY_MAX = 3
) (
  // Clock and reset
  input wire clk_in,
  input wire rst_in,
  // Register bus
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire [31:0] prdata_out,
  input wire pready_out,
  input wire pslverr_out,
  // Bit streams
  input wire tx_ready_in,
  input wire tx_bit_out,
  input wire tx_strobe_out,
  input wire rx_valid_in,
  input wire rx_bit_in,
  input wire rx_listen_out
);
  // ==========================================
  // Frame tracking
  // Peer never stalls twice in a row, so a long gap marks a new frame
  logic [4:0] gap_q;
  logic [3:0] nb_q;
  logic last_q;
  always @(posedge clk_in) begin
    if (rst_in) begin
      gap_q <= 5'h1f;
      nb_q <= 4'h0;
      last_q <= 1'b0;
    end else begin
      gap_q <= tx_strobe_out ? 5'h00 : (gap_q == 5'h1f ? gap_q : gap_q + 5'h01);
      if (tx_strobe_out) begin
        nb_q <= gap_q > 5'h08 ? 4'h1 : (nb_q == 4'hf ? nb_q : nb_q + 4'h1);
        last_q <= tx_bit_out;
      end
    end
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  sequence s_bad_addr;
    s_setup ##0 (paddr_in > 8'h2c || paddr_in[1:0] != 2'h0);
  endsequence
  property p_ready_wait;
    s_setup |=> !pready_out ##1 pready_out;
  endproperty
  property p_ready_pulse;
    pready_out |=> !pready_out;
  endproperty
  property p_err_ready;
    pslverr_out |-> pready_out;
  endproperty
  property p_unmapped;
    s_bad_addr |-> ##2 (pready_out && pslverr_out);
  endproperty
  property p_err_data;
    pready_out && pslverr_out && !pwrite_in |-> prdata_out == 32'h0;
  endproperty
  property p_strobe_cause;
    tx_strobe_out |-> $past(tx_ready_in);
  endproperty
  property p_preamble;
    tx_strobe_out && nb_q != 4'h0 && nb_q < 4'h9 && gap_q < 5'h09 |-> tx_bit_out != last_q;
  endproperty
  property p_listen_reset;
    $fell(rst_in) |-> !rx_listen_out;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("pready not in second access cycle");
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  a_err_data: assert property (p_err_data) else $error("refused read data not zero");
  a_strobe_cause: assert property (p_strobe_cause) else $error("bit strobe without tick");
  a_preamble: assert property (p_preamble) else $error("preamble not alternating");
  a_listen_reset: assert property (p_listen_reset) else $error("listening after reset");
endmodule
bind radio_packet_link_framer radio_framer_monitor #(.ACK_WAIT_CYCLES(ACK_WAIT_CYCLES), .RETRY_MAX(RETRY_MAX)) mon (
  .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
  .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .tx_ready_in(tx_ready_in), .tx_bit_out(tx_bit_out),
  .tx_strobe_out(tx_strobe_out), .rx_valid_in(rx_valid_in), .rx_bit_in(rx_bit_in),
  .rx_listen_out(rx_listen_out));

//--- bench/radio_peer.sv
`timescale 1ns/1ps
module radio_peer (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Bits from the device
  input wire logic tx_bit_in,
  input wire logic tx_strobe_in,
  output logic tx_ready_out,
  // Bits toward the device
  output logic rx_valid_out,
  output logic rx_bit_out
);
  logic got[$];
  initial begin
    tx_ready_out = 1'b0;
    rx_valid_out = 1'b0;
    rx_bit_out = 1'b1;
  end
  // ==========================================
  // Modulator side: stalls, but never twice in a row
  always @(posedge clk_in) begin
    tx_ready_out <= !rst_in && (!tx_ready_out || $urandom % 3 != 0);
    if (tx_strobe_in)
      got.push_back(tx_bit_in);
  end
  // ==========================================
  // Demodulator side: idle line shows the inverse of the last bit
  task automatic send(input bit b[$]);
    foreach (b[i]) begin
      if ($urandom % 4 == 0) begin
        rx_valid_out <= 1'b0;
        rx_bit_out <= ~rx_bit_out;
        @(posedge clk_in);
      end
      rx_valid_out <= 1'b1;
      rx_bit_out <= b[i];
      @(posedge clk_in);
    end
    rx_valid_out <= 1'b0;
    rx_bit_out <= ~b[b.size() - 1];
  endtask
endmodule

//--- bench/tb_top.sv
`timescale 1ns/1ps
`include "radio_framer_defines.vh"
module tb_top;
  // ==========================================
  // Clock, reset and wiring
  logic clk_in = 1'b0, rst_in = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, rerr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rdv;
  logic [39:0] ta, ra;
  wire [31:0] prdata;
  wire pready, pslverr, tx_bit, tx_stb, tx_rdy, rx_val, rx_bit, listen;
  int errors = 0, samples_checked = 0, len, n;
  bit q[$];
  byte pl[$];
  always #2 clk_in = ~clk_in;
  radio_packet_link_framer #(.ACK_WAIT_CYCLES(200), .RETRY_MAX(3)) dut (.clk_in(clk_in), .rst_in(rst_in),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .tx_ready_in(tx_rdy),
    .tx_bit_out(tx_bit), .tx_strobe_out(tx_stb), .rx_valid_in(rx_val), .rx_bit_in(rx_bit),
    .rx_listen_out(listen));
  radio_peer peer (.clk_in(clk_in), .rst_in(rst_in), .tx_bit_in(tx_bit), .tx_strobe_in(tx_stb),
    .tx_ready_out(tx_rdy), .rx_valid_out(rx_val), .rx_bit_out(rx_bit));
  // ==========================================
  // Shared tasks
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(bit w, logic [7:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    pen <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    rdv = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic wait_st(logic [31:0] m);
    do apb(1'b0, `REG_STATUS, 32'h0); while ((rdv & m) == 32'h0);
  endtask
  // Reference frame, CRC worked bit by bit in send order
  function automatic void build(int aw, logic [39:0] ad, int ln, int packet_identity, bit sk, bit c2);
    int w = c2 ? 16 : 8;
    int crc = c2 ? 32'hffff : 32'hff;
    q.delete();
    for (int i = aw * 8 - 1; i >= 0; i--) q.push_back(ad[i]);
    for (int i = 5; i >= 0; i--) q.push_back(ln[i]);
    q.push_back(packet_identity[1]);
    q.push_back(packet_identity[0]);
    q.push_back(sk);
    foreach (pl[k]) for (int i = 7; i >= 0; i--) q.push_back(pl[k][i]);
    foreach (q[i]) crc = ((crc << 1) & ((1 << w) - 1)) ^ ((((crc >> (w - 1)) & 1) ^ q[i]) ?
      (c2 ? 32'h1021 : 32'h07) : 32'h0);
    for (int i = w - 1; i >= 0; i--) q.push_back(crc[i]);
    for (int i = 0; i < 8; i++) q.push_front(~(ad[aw * 8 - 1] ^ i[0]));
  endfunction
  task automatic end_sim;
    $display("checks %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    $display("watchdog expired");
    end_sim;
  end
  // ==========================================
  // Tests
  initial begin
    void'($urandom(61279));
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    apb(1'b0, `REG_CONFIG, 32'h0);
    chk("config_reset", rdv, 32'h13);
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped_data", rdv, 32'h0);
    chk("unmapped_err", rerr, 32'h1);
    $display("test registers done");
    ta = {$urandom, $urandom};
    apb(1'b1, `REG_TX_ADDR_LO, ta[31:0]);
    apb(1'b1, `REG_TX_ADDR_HI, {24'h0, ta[39:32]});
    for (int t = 0; t < 4; t++) begin
      len = t == 1 ? 32 : t == 0 ? 1 : 1 + $urandom % 31;
      apb(1'b1, `REG_CONFIG, (t % 3 + 1) | (t[0] << 2) | (t == 2 ? 32'h0 : 32'h60) | 32'h80);
      apb(1'b1, `REG_STATIC_WIDTH, len);
      pl.delete();
      for (int i = 0; i < len; i++) begin
        pl.push_back($urandom);
        apb(1'b1, (t < 3 && i == len - 1) ? `REG_TX_DATA_SKIPACK : `REG_TX_DATA, {24'h0, pl[i]});
      end
      build(t % 3 + 3, ta, t == 2 ? 0 : len, t + 1, t < 3, t[0]);
      peer.got.delete();
      apb(1'b1, `REG_COMMAND, 32'h1);
      wait_st(32'h6);
      chk("tx_bits", peer.got.size(), q.size() * (t < 3 ? 1 : 4));
      foreach (peer.got[i]) chk("tx_bit", peer.got[i], q[i % q.size()]);
      chk("tx_status", rdv[5:0], {t[1:0] + 2'h1, 1'b0, t == 3, t < 3, 1'b0});
      apb(1'b1, `REG_STATUS, 32'h6);
    end
    $display("test transmit done");
    ra = {$urandom, $urandom};
    apb(1'b1, `REG_RX_ADDR_LO, ra[31:0]);
    apb(1'b1, `REG_CONFIG, 32'h79);
    chk("rx_listen", listen, 32'h1);
    for (int k = 0; k < 4; k++) begin
      if (k != 1) begin
        pl.delete();
        len = 1 + $urandom % 32;
        repeat (len) pl.push_back($urandom);
      end
      build(3, ra, len, k == 3 ? 2 : 1, k < 3, 1'b0);
      if (k == 2) q[q.size() - 1] = ~q[q.size() - 1];
      peer.got.delete();
      peer.send(q);
      repeat (3) @(posedge clk_in);
      apb(1'b0, `REG_STATUS, 32'h0);
      chk("rx_ready", rdv[0], k == 0 || k == 3);
      if (rdv[0] === 1'b1) begin
        apb(1'b0, `REG_RX_WIDTH, 32'h0);
        chk("rx_width", rdv, len);
        foreach (pl[i]) begin
          apb(1'b0, `REG_RX_DATA, 32'h0);
          chk("rx_data", rdv, {24'h0, pl[i]});
        end
        apb(1'b1, `REG_STATUS, 32'h1);
      end
      if (k == 3) begin
        // Acknowledge carries no payload
        pl.delete();
        build(3, ta, 0, 2, 1'b0, 1'b0);
        n = 0;
        while (peer.got.size() < q.size() && n++ < 500) @(posedge clk_in);
      end else
        q.delete();
      chk("ack_bits", peer.got.size(), q.size());
      foreach (peer.got[i]) chk("ack_bit", peer.got[i], q[i]);
    end
    $display("test receive done");
    end_sim;
  end
endmodule
